/* File: rtl/ldw_fifo.sv */
// Purpose: Byte FIFO between bus receiver and display memory writer
// Assumes: Single clock, synchronous reset
// Notes:   Pushes refused when full; pops refused when empty
`timescale 1ns/100ps
module ldw_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 8
) (
   input  wire logic             core_clk_i,
   input  wire logic             sys_rst_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
         $error("ldw_fifo: DEPTH must be a power of two >= 2");
      end
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]      cnt_q, cnt_d;
   logic             push, pop;

   assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o  = mem_q[rd_q];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   always_comb begin
      wr_d  = push ? wr_q + 1'b1 : wr_q;
      rd_d  = pop  ? rd_q + 1'b1 : rd_q;
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end
endmodule // ldw_fifo

/* File: rtl/ldw_pkg.sv */
// Purpose: Shared constants and types for the display memory write path
// Assumes: Single clock, synchronous active-high reset
// Notes:   Drive mode encodings follow backplane count
package ldw_pkg;

   // ==========================================================================
   // Geometry
   // ==========================================================================
   localparam int unsigned COLS      = 60;
   localparam int unsigned ROWS      = 4;
   localparam int unsigned PTR_W     = 6;
   localparam int unsigned SUB_W     = 3;
   localparam int unsigned FIFO_W    = 8;
   localparam int unsigned FIFO_D    = 8;

   // ==========================================================================
   // Drive modes and pointer steps
   // ==========================================================================
   localparam logic [1:0] MODE_STATIC = 2'h0;
   localparam logic [1:0] MODE_MUX2   = 2'h1;
   localparam logic [1:0] MODE_MUX3   = 2'h2;
   localparam logic [1:0] MODE_MUX4   = 2'h3;
   localparam logic [3:0] STEP_STATIC = 4'h8;
   localparam logic [3:0] STEP_MUX2   = 4'h4;
   localparam logic [3:0] STEP_MUX3   = 4'h3;
   localparam logic [3:0] STEP_MUX4   = 4'h2;

   // ==========================================================================
   // Reset values
   // ==========================================================================
   localparam logic [PTR_W-1:0] PTR_RST = 6'h00;
   localparam logic [SUB_W-1:0] SUB_RST = 3'h0;

   // ==========================================================================
   // Carrier types
   // ==========================================================================
   typedef struct packed {
      logic [1:0] mode;
      logic       alt_bank;
   } ldw_cfg_type;

   typedef struct packed {
      logic             load_ptr;
      logic [PTR_W-1:0] ptr_val;
      logic             load_sub;
      logic [SUB_W-1:0] sub_val;
   } ldw_cmd_type;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_WRITE = 3'b010,
      ST_ADV   = 3'b100
   } ldw_state_type;

endpackage : ldw_pkg

/* File: rtl/ldw_write_path.sv */
// Purpose: Display memory, byte unpacking, pointer and subaddress logic
// Assumes: Bytes and commands already decoded from the bus, synchronous
// Notes:   Memory rows feed backplane slots; columns feed segments
`timescale 1ns/100ps
module ldw_write_path #(
   parameter int unsigned NCOLS = ldw_pkg::COLS,
   parameter int unsigned FDEP  = ldw_pkg::FIFO_D
) (
   input  wire logic                       core_clk_i,
   input  wire logic                       sys_rst_i,
   input  wire ldw_pkg::ldw_cfg_type       cfg_i,
   input  wire ldw_pkg::ldw_cmd_type       cmd_i,
   input  wire logic                       byte_valid_i,
   output logic                            byte_ready_o,
   input  wire logic [7:0]                 byte_data_i,
   input  wire logic                       subaddr_pin_0_i,
   input  wire logic                       subaddr_pin_1_i,
   input  wire logic                       subaddr_pin_2_i,
   input  wire logic [3:0]                 bp_wave_i,
   input  wire logic [1:0]                 out_row_i,
   output logic      [3:0]                 backplane_outputs_o,
   output logic      [NCOLS-1:0]           segment_outputs_o,
   output logic      [ldw_pkg::PTR_W-1:0]  data_ptr_o,
   output logic      [ldw_pkg::SUB_W-1:0]  sub_cnt_o,
   output logic                            busy_o
);
   initial begin
      if (NCOLS != ldw_pkg::COLS || FDEP < 2) begin
         $error("ldw_write_path: unsupported NCOLS or FDEP");
      end
   end

   // ==========================================================================
   // Input FIFO
   // ==========================================================================
   logic       fq_valid;
   logic       fq_ready;
   logic [7:0] fq_data;

   ldw_fifo #(
      .WIDTH (ldw_pkg::FIFO_W),
      .DEPTH (FDEP)
   ) u_fifo (
      .core_clk_i  (core_clk_i),
      .sys_rst_i   (sys_rst_i),
      .in_valid_i  (byte_valid_i),
      .in_ready_o  (byte_ready_o),
      .in_data_i   (byte_data_i),
      .out_valid_o (fq_valid),
      .out_ready_i (fq_ready),
      .out_data_o  (fq_data)
   );

   // ==========================================================================
   // Helpers
   // ==========================================================================
   function automatic logic [3:0] step_of(input logic [1:0] mode);
      case (mode)
         ldw_pkg::MODE_STATIC: step_of = ldw_pkg::STEP_STATIC;
         ldw_pkg::MODE_MUX2:   step_of = ldw_pkg::STEP_MUX2;
         ldw_pkg::MODE_MUX3:   step_of = ldw_pkg::STEP_MUX3;
         default:              step_of = ldw_pkg::STEP_MUX4;
      endcase
   endfunction

   // ==========================================================================
   // Display memory
   // ==========================================================================
   logic [3:0] ram_q [NCOLS];
   logic [3:0] ram_d [NCOLS];

   // ==========================================================================
   // Control state
   // ==========================================================================
   ldw_pkg::ldw_state_type    st_q, st_d;
   logic [ldw_pkg::PTR_W-1:0] ptr_q, ptr_d;
   logic [ldw_pkg::SUB_W-1:0] sub_q, sub_d;
   logic [7:0]                byte_q, byte_d;
   logic [2:0]                pins;
   logic                      match;
   logic [6:0]                ptr_sum;

   assign pins     = {subaddr_pin_2_i, subaddr_pin_1_i, subaddr_pin_0_i};
   assign match    = (sub_q == pins);
   assign ptr_sum  = {1'b0, ptr_q} + {3'h0, step_of(cfg_i.mode)};
   assign fq_ready = (st_q == ldw_pkg::ST_IDLE) && !cmd_i.load_ptr;
   assign busy_o   = (st_q != ldw_pkg::ST_IDLE);

   always_comb begin
      int unsigned c;
      int unsigned col;
      c       = 0;
      col     = 0;
      st_d    = st_q;
      ptr_d   = ptr_q;
      sub_d   = sub_q;
      byte_d  = byte_q;
      ram_d   = ram_q;
      case (st_q)
         ldw_pkg::ST_IDLE: begin
            if (cmd_i.load_ptr) begin
               ptr_d = cmd_i.ptr_val;
            end else if (fq_valid) begin
               byte_d = fq_data;
               st_d   = ldw_pkg::ST_WRITE;
            end
         end
         ldw_pkg::ST_WRITE: begin
            if (match) begin
               for (c = 0; c < 8; c++) begin
                  col = int'(ptr_q) + c;
                  if (col < NCOLS) begin
                     case (cfg_i.mode)
                        ldw_pkg::MODE_STATIC: begin
                           if (c < 8) begin
                              ram_d[col][cfg_i.alt_bank ? 2 : 0] = byte_q[7-c];
                           end
                        end
                        ldw_pkg::MODE_MUX2: begin
                           if (c < 4) begin
                              ram_d[col][cfg_i.alt_bank ? 2 : 0] = byte_q[7-2*c];
                              ram_d[col][cfg_i.alt_bank ? 3 : 1] = byte_q[6-2*c];
                           end
                        end
                        ldw_pkg::MODE_MUX3: begin
                           if (c < 3) begin
                              ram_d[col][0] = byte_q[7-3*c];
                              ram_d[col][1] = byte_q[6-3*c];
                              if (c < 2) begin
                                 ram_d[col][2] = byte_q[5-3*c];
                              end
                           end
                        end
                        default: begin
                           if (c < 2) begin
                              ram_d[col] = {byte_q[4-4*c], byte_q[5-4*c],
                                            byte_q[6-4*c], byte_q[7-4*c]};
                           end
                        end
                     endcase
                  end
               end
            end
            st_d = ldw_pkg::ST_ADV;
         end
         ldw_pkg::ST_ADV: begin
            // Advances whether or not the byte was stored
            if (ptr_sum >= 7'(NCOLS)) begin
               ptr_d = '0;
               sub_d = sub_q + 1'b1;
            end else begin
               ptr_d = ptr_sum[ldw_pkg::PTR_W-1:0];
            end
            st_d = ldw_pkg::ST_IDLE;
         end
         default: begin
            st_d = ldw_pkg::ST_IDLE;
         end
      endcase
      if (cmd_i.load_sub) begin
         sub_d = cmd_i.sub_val;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         st_q   <= ldw_pkg::ST_IDLE;
         ptr_q  <= ldw_pkg::PTR_RST;
         sub_q  <= ldw_pkg::SUB_RST;
         byte_q <= 8'h00;
         for (int i = 0; i < NCOLS; i++) begin
            ram_q[i] <= 4'h0;
         end
      end else begin
         st_q   <= st_d;
         ptr_q  <= ptr_d;
         sub_q  <= sub_d;
         byte_q <= byte_d;
         ram_q  <= ram_d;
      end
   end

   // ==========================================================================
   // Output side: segments and backplane duplication
   // ==========================================================================
   logic [3:0]       bp_d;
   logic [3:0]       bp_q;
   logic [NCOLS-1:0] seg_d;
   logic [NCOLS-1:0] seg_q;

   always_comb begin
      for (int k = 0; k < NCOLS; k++) begin
         seg_d[k] = ram_q[k][out_row_i];
      end
      case (cfg_i.mode)
         ldw_pkg::MODE_STATIC: bp_d = {4{bp_wave_i[0]}};
         ldw_pkg::MODE_MUX2:   bp_d = {bp_wave_i[1:0], bp_wave_i[1:0]};
         ldw_pkg::MODE_MUX3:   bp_d = {bp_wave_i[1], bp_wave_i[2:0]};
         default:              bp_d = bp_wave_i;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         bp_q  <= 4'h0;
         seg_q <= '0;
      end else begin
         bp_q  <= bp_d;
         seg_q <= seg_d;
      end
   end

   assign backplane_outputs_o = bp_q;
   assign segment_outputs_o   = seg_q;
   assign data_ptr_o          = ptr_q;
   assign sub_cnt_o           = sub_q;
endmodule // ldw_write_path

/* File: tb/ldw_host_model.sv */
// Purpose: Bus host stand-in feeding display bytes and commands
// Assumes: Caller sits just after a rising edge
// Notes:   Data lines show an inverted pattern once released
`timescale 1ns/100ps
module ldw_host_model (
   input  wire logic            core_clk_i,
   input  wire logic            byte_ready_i,
   output logic                 byte_valid_o,
   output logic [7:0]           byte_data_o,
   output ldw_pkg::ldw_cmd_type cmd_o
);
   // ==========================================================================
   // Host tasks
   // ==========================================================================
   initial begin
      byte_valid_o = 1'b0;
      byte_data_o  = 8'h00;
      cmd_o        = '0;
   end
   task automatic send(input logic [7:0] b);
      byte_valid_o <= 1'b1;
      byte_data_o  <= b;
      do @(posedge core_clk_i); while (!byte_ready_i);
      // One byte per call; drop valid so no repeat push follows
      byte_valid_o <= 1'b0;
   endtask
   task automatic idle();
      byte_valid_o <= 1'b0;
      byte_data_o  <= ~byte_data_o;
      @(posedge core_clk_i);
   endtask
   // Pick the device first, then reload its pointer
   task automatic select(input logic [2:0] s, input logic [5:0] p);
      cmd_o <= '{1'b0, 6'h00, 1'b1, s};
      @(posedge core_clk_i);
      cmd_o <= '{1'b1, p, 1'b0, 3'h0};
      @(posedge core_clk_i);
      cmd_o <= '0;
      @(posedge core_clk_i);
   endtask
   task automatic stall(input logic on);
      cmd_o <= '{on, 6'h00, 1'b0, 3'h0};
      @(posedge core_clk_i);
   endtask
endmodule // ldw_host_model

/* File: tb/ldw_write_path_props.sv */
// Purpose: Port assertions for the display write path
// Assumes: Mode and subaddress pins steady while bytes flow
// Notes:   Bound at the foot of this file
`timescale 1ns/100ps
module ldw_write_path_props #(
   parameter int unsigned NCOLS = 60
) (
   input wire logic                 core_clk_i,
   input wire logic                 sys_rst_i,
   input wire ldw_pkg::ldw_cfg_type cfg_i,
   input wire ldw_pkg::ldw_cmd_type cmd_i,
   input wire logic                 byte_valid_i,
   input wire logic                 byte_ready_o,
   input wire logic                 subaddr_pin_0_i,
   input wire logic                 subaddr_pin_1_i,
   input wire logic                 subaddr_pin_2_i,
   input wire logic [3:0]           bp_wave_i,
   input wire logic [1:0]           out_row_i,
   input wire logic [3:0]           backplane_outputs_o,
   input wire logic [NCOLS-1:0]     segment_outputs_o,
   input wire logic [5:0]           data_ptr_o,
   input wire logic [2:0]           sub_cnt_o,
   input wire logic                 busy_o
);
   // ==========================================================================
   // Checks
   // ==========================================================================
   localparam logic [15:0] STEPS = {ldw_pkg::STEP_MUX4, ldw_pkg::STEP_MUX3,
                                    ldw_pkg::STEP_MUX2, ldw_pkg::STEP_STATIC};
   logic [6:0] sum;
   logic [5:0] nxt;
   logic [2:0] pins;
   assign pins = {subaddr_pin_2_i, subaddr_pin_1_i, subaddr_pin_0_i};
   assign sum  = {1'b0, data_ptr_o} + {3'h0, STEPS[cfg_i.mode*4 +: 4]};
   assign nxt  = (sum >= NCOLS) ? 6'h00 : sum[5:0];
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   AST_BP_MUX3:
   assert property (cfg_i.mode == ldw_pkg::MODE_MUX3 |=> backplane_outputs_o ==
      {$past(bp_wave_i[1]), $past(bp_wave_i[2:0])}) else $error("bp 1:3 wrong");
   AST_BP_MUX2:
   assert property (cfg_i.mode == ldw_pkg::MODE_MUX2 |=> backplane_outputs_o ==
      {2{$past(bp_wave_i[1:0])}}) else $error("bp 1:2 wrong");
   AST_BP_STATIC:
   assert property (cfg_i.mode == ldw_pkg::MODE_STATIC |=> backplane_outputs_o ==
      {4{$past(bp_wave_i[0])}}) else $error("bp static wrong");
   AST_PTR_LOAD:
   assert property (cmd_i.load_ptr && !busy_o |=> data_ptr_o == $past(cmd_i.ptr_val))
      else $error("pointer load lost");
   AST_PTR_STEP:
   assert property ($changed(data_ptr_o) && !$past(cmd_i.load_ptr) |-> data_ptr_o == $past(nxt))
      else $error("pointer step wrong");
   AST_SUB_LOAD:
   assert property (cmd_i.load_sub |=> sub_cnt_o == $past(cmd_i.sub_val))
      else $error("subaddress load lost");
   AST_SUB_WRAP:
   assert property ($changed(data_ptr_o) && data_ptr_o == 6'h00 && !$past(cmd_i.load_ptr)
      && !$past(cmd_i.load_sub) |-> sub_cnt_o == $past(sub_cnt_o) + 3'h1)
      else $error("subaddress not stepped");
   AST_NO_WRITE:
   assert property ((sub_cnt_o != pins)[*4] ##0 $past(out_row_i) == $past(out_row_i, 2)
      |-> $stable(segment_outputs_o)) else $error("write while unmatched");
   COV_FULL: cover property (byte_valid_i && !byte_ready_o);
   COV_WRAP: cover property ($changed(sub_cnt_o) && !$past(cmd_i.load_sub));
   COV_BANK: cover property (cfg_i.alt_bank && busy_o);
endmodule // ldw_write_path_props

bind ldw_write_path ldw_write_path_props #(.NCOLS(NCOLS)) u_props (.*);

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the display write path
// Assumes: Host model issues bytes and commands
// Notes:   Reference memory tracked per accepted byte
`timescale 1ns/100ps
module testbench;
   // ==========================================================================
   // Bench
   // ==========================================================================
   localparam logic [15:0] BPX = {4'hd, 4'h5, 4'h5, 4'hf};
   logic                 core_clk_i = 1'b0;
   logic                 sys_rst_i = 1'b1;
   ldw_pkg::ldw_cfg_type cfg_i = '0;
   ldw_pkg::ldw_cmd_type cmd_i;
   logic                 byte_valid_i, byte_ready_o, busy_o;
   logic [7:0]           byte_data_i;
   logic                 subaddr_pin_0_i = 1'b1; // Held steady
   logic                 subaddr_pin_1_i = 1'b0;
   logic                 subaddr_pin_2_i = 1'b1;
   logic [3:0]           bp_wave_i = 4'hd;
   logic [1:0]           out_row_i = 2'h0;
   logic [3:0]           backplane_outputs_o;
   logic [59:0]          segment_outputs_o;
   logic [5:0]           data_ptr_o, mp = 6'h00;
   logic [2:0]           sub_cnt_o, ms = 3'h0;
   logic [3:0]           m [60];
   int                   fail_count = 0, total_checks = 0, cyc = 0;
   always #2 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         summarize();
      end
   end
   ldw_write_path u_ldw_write_path (.*);
   ldw_host_model u_ldw_host_model (.core_clk_i(core_clk_i), .byte_ready_i(byte_ready_o),
      .byte_valid_o(byte_valid_i), .byte_data_o(byte_data_i), .cmd_o(cmd_i));
   task automatic cmp(input string n, input logic [63:0] e, input logic [63:0] g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic xfer(input logic [7:0] b);
      int k, c;
      u_ldw_host_model.send(b);
      // Let pop, write and advance finish before mode or commands change
      repeat (5) @(posedge core_clk_i);
      k = int'(cfg_i.mode) + 1;
      for (int i = 0; i < 8; i++) begin
         c = mp + i / k;
         if (c < 60 && ms == 3'h5) m[c][((cfg_i.alt_bank && k < 3) ? 2 : 0) + i % k] = b[7-i];
      end
      c = mp + (8 + k - 1) / k;
      mp = (c >= 60) ? 6'h00 : 6'(c);
      ms = (c >= 60) ? ms + 3'h1 : ms;
   endtask
   task automatic pick(input logic [2:0] s, input logic [5:0] p);
      u_ldw_host_model.select(s, p);
      ms = s;
      mp = p;
   endtask
   task automatic chk();
      logic [59:0] e;
      u_ldw_host_model.idle();
      repeat (40) @(posedge core_clk_i);
      for (int r = 0; r < 4; r++) begin
         out_row_i <= 2'(r);
         repeat (3) @(posedge core_clk_i);
         #1;
         for (int k = 0; k < 60; k++) e[k] = m[k][r];
         cmp("segments", {4'h0, e}, {4'h0, segment_outputs_o});
      end
      cmp("pointer", {58'h0, mp}, {58'h0, data_ptr_o});
      cmp("subaddr", {61'h0, ms}, {61'h0, sub_cnt_o});
      cmp("backplanes", {60'h0, BPX[cfg_i.mode*4 +: 4]}, {60'h0, backplane_outputs_o});
   endtask
   task automatic t_modes();
      for (int md = 0; md < 4; md++) begin
         cfg_i <= '{2'(md), 1'b0};
         pick(3'h5, 6'(md * 12 + 1));
         xfer(8'ha5 ^ 8'(md));
         xfer(8'h3c + 8'(md));
         chk();
      end
   endtask
   task automatic t_bank();
      cfg_i <= '{ldw_pkg::MODE_STATIC, 1'b1};
      pick(3'h5, 6'd40);
      xfer(8'h96);
      cfg_i <= '{ldw_pkg::MODE_MUX2, 1'b1};
      pick(3'h5, 6'd48);
      xfer(8'h69);
      chk();
      cfg_i <= '{ldw_pkg::MODE_MUX2, 1'b0};
   endtask
   task automatic t_mismatch();
      cfg_i <= '{ldw_pkg::MODE_MUX4, 1'b0};
      pick(3'h2, 6'd30);
      xfer(8'hff);
      chk();
   endtask
   task automatic t_wrap();
      cfg_i <= '{ldw_pkg::MODE_STATIC, 1'b0};
      pick(3'h5, 6'd56);
      xfer(8'hf0);
      xfer(8'h0f);
      chk();
   endtask
   task automatic t_fifo();
      cfg_i <= '{ldw_pkg::MODE_MUX4, 1'b0};
      pick(3'h5, 6'd0);
      u_ldw_host_model.stall(1'b1);
      for (int i = 0; i < 8; i++) xfer(8'h11 * 8'(i));
      #1;
      cmp("ready", 64'h0, {63'h0, byte_ready_o});
      u_ldw_host_model.idle();
      u_ldw_host_model.stall(1'b0);
      chk();
   endtask
   task automatic summarize();
      $display("Checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      foreach (m[k]) m[k] = 4'h0;
      repeat (12) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge core_clk_i);
      chk();
      t_modes();
      t_bank();
      t_mismatch();
      t_wrap();
      t_fifo();
      summarize();
   end
endmodule // testbench
